/* verilog/uart_line_status_flags.sv */
// Line status flags: error summary, transmitter empty, holding empty, break
//
// Overview of operation
// RULE_01 - Non-FIFO: error flag follows buffer, read clears
// RULE_02 - FIFO: error flag while any erroneous entry
// RULE_03 - Non-FIFO: empty when holding and shifter empty
// RULE_04 - FIFO: empty when FIFO and shifter empty
// RULE_05 - Holding empty with enable raises interrupt
// RULE_06 - Non-FIFO: load clears, transfer sets holding empty
// RULE_07 - FIFO: write clears, last transfer sets
// RULE_08 - Host writes transmit FIFO only when not full
// RULE_09 - Break when line low beyond character time
// RULE_10 - Break flag with enable raises interrupt
// RULE_11 - Non-FIFO: break tied to buffer, read clears
// RULE_12 - FIFO: break clears unless next entry tagged
// RULE_13 - FIFO: break flag reports head entry
// RULE_14 - Host never writes the line status register
// RULE_15 - Parity, framing, break tags stored per entry
// RULE_16 - Bits above seven read as zero
//
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module uart_line_status_flags
  import uart_lsf_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // Avalon-MM slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Receiver side
  input  wire logic        rxLine,
  input  wire logic        baudTick,
  input  wire logic [3:0]  charBits,
  input  wire logic        rxCharValid,
  input  wire rx_tag_t     rxCharTag,
  input  wire logic        rxRead,
  // Transmitter side
  input  wire logic        txWrite,
  input  wire logic        txShiftLoad,
  input  wire logic        txShiftBusy,
  output logic             txFull,
  // Interrupts
  output logic             txEmptyIrq,
  output logic             lineStatusIrq,
  output logic             irq
);

  // Control and interrupt registers
  logic [2:0]  control;
  logic [2:0]  next_control;
  logic [2:0]  irqStatus;
  logic [2:0]  next_irqStatus;
  logic [2:0]  irqMask;
  logic [2:0]  next_irqMask;
  logic        ack;
  logic        next_ack;
  logic [31:0] next_readdata;

  // Receive tag store
  rx_tag_t           tagMem [0:15];
  logic [PTR_W-1:0]  rdPtr;
  logic [PTR_W-1:0]  next_rdPtr;
  logic [PTR_W-1:0]  wrPtr;
  logic [PTR_W-1:0]  next_wrPtr;
  logic [CNT_W-1:0]  rxCount;
  logic [CNT_W-1:0]  next_rxCount;
  logic [CNT_W-1:0]  errCount;
  logic [CNT_W-1:0]  next_errCount;
  logic              memWe;
  logic [PTR_W-1:0]  memIdx;

  // Transmit occupancy
  logic [CNT_W-1:0]  txCount;
  logic [CNT_W-1:0]  next_txCount;
  logic              fifoModeQ;

  logic              fifoMode;
  logic              flush;
  logic              breakPulse;
  logic              pushValid;
  rx_tag_t           pushTag;
  logic              pushErr;
  logic              pop;
  rx_tag_t           headTag;
  logic              headErr;
  logic              txAccept;
  logic              txDrain;
  line_flags_t       flags;
  line_flags_t       prevFlags;
  logic [31:0]       lineStatusWord;
  logic              busReq;
  logic              wrTaken;

  break_detect break_detect_i (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .rxLine     (rxLine),
    .baudTick   (baudTick),
    .charBits   (charBits),
    .breakPulse (breakPulse)
  );

  assign fifoMode = control[CTRL_FIFO_BIT];
  // Mode change empties both sides so stale tags never reach the head
  assign flush    = fifoMode != fifoModeQ;

  // Receive tags
  always_comb begin
    pushValid = rxCharValid | breakPulse;
    pushTag   = rxCharTag;
    pushTag.brk = rxCharTag.brk | breakPulse; // [RULE_09]
    pushErr   = pushTag.parity | pushTag.framing | pushTag.brk;
    headTag   = tagMem[rdPtr];
    headErr   = headTag.parity | headTag.framing | headTag.brk;
    pop       = rxRead && rxCount != '0;
  end

  always_comb begin
    next_rdPtr    = rdPtr;
    next_wrPtr    = wrPtr;
    next_rxCount  = rxCount;
    next_errCount = errCount;
    memWe         = 1'b0;
    memIdx        = wrPtr;
    if (flush) begin
      next_rdPtr    = '0;
      next_wrPtr    = '0;
      next_rxCount  = '0;
      next_errCount = '0;
    end else if (!fifoMode) begin
      // Single buffer: a new character overwrites, a read empties
      if (pushValid) begin // [RULE_11]
        memWe         = 1'b1;
        memIdx        = rdPtr;
        next_rxCount  = BUF_DEPTH;
        next_errCount = {4'h0, pushErr};
      end else if (pop) begin // [RULE_01]
        next_rxCount  = '0;
        next_errCount = '0;
      end
    end else begin
      if (pop) begin // [RULE_12]
        next_rdPtr    = rdPtr + 4'h1;
        next_rxCount  = next_rxCount - 5'h01;
        next_errCount = next_errCount - {4'h0, headErr};
      end
      // Overrun drops the character when the store is full
      if (pushValid && next_rxCount < FIFO_DEPTH) begin // [RULE_15]
        memWe         = 1'b1;
        next_wrPtr    = wrPtr + 4'h1;
        next_rxCount  = next_rxCount + 5'h01;
        next_errCount = next_errCount + {4'h0, pushErr};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (memWe) begin
      tagMem[memIdx] <= pushTag; // [RULE_15]
    end
  end

  // Transmit occupancy
  always_comb begin
    txFull    = txCount >= (fifoMode ? FIFO_DEPTH : BUF_DEPTH);
    txAccept  = txWrite && !txFull; // [RULE_08]
    txDrain   = txShiftLoad && txCount != '0;
    next_txCount = txCount;
    if (flush) begin
      next_txCount = '0;
    end else begin
      if (txAccept) begin // [RULE_06] [RULE_07]
        next_txCount = next_txCount + 5'h01;
      end
      if (txDrain) begin // [RULE_06] [RULE_07]
        next_txCount = next_txCount - 5'h01;
      end
    end
  end

  // Flag derivation
  always_comb begin
    flags.errorSummary = fifoMode ? (errCount != '0) // [RULE_02]
                                  : (rxCount != '0 && headErr); // [RULE_01]
    flags.transmitterEmpty = txCount == '0 && !txShiftBusy; // [RULE_03] [RULE_04]
    flags.txHoldingEmpty   = txCount == '0; // [RULE_06] [RULE_07]
    flags.breakFlag        = rxCount != '0 && headTag.brk; // [RULE_11] [RULE_13]
    lineStatusWord = '0; // [RULE_16]
    lineStatusWord[ERR_SUMMARY_BIT] = flags.errorSummary;
    lineStatusWord[TX_EMPTY_BIT]    = flags.transmitterEmpty;
    lineStatusWord[HOLD_EMPTY_BIT]  = flags.txHoldingEmpty;
    lineStatusWord[BREAK_BIT]       = flags.breakFlag;
    txEmptyIrq    = flags.txHoldingEmpty && control[CTRL_TXIRQ_BIT]; // [RULE_05]
    lineStatusIrq = flags.breakFlag && control[CTRL_LSIRQ_BIT]; // [RULE_10]
    irq           = |(irqStatus & irqMask);
  end

  // Bus slave: one wait cycle, answer at the second edge
  always_comb begin
    busReq      = read | write;
    waitrequest = busReq && !ack;
    next_ack    = busReq && !ack;
    wrTaken     = write && ack;
    next_readdata = readdata;
    if (read && !ack) begin
      case (address)
        LINE_STATUS_OFS: next_readdata = lineStatusWord;
        CONTROL_OFS:     next_readdata = {29'h0, control};
        IRQ_STATUS_OFS:  next_readdata = {29'h0, irqStatus};
        IRQ_MASK_OFS:    next_readdata = {29'h0, irqMask};
        default:         next_readdata = 32'h0;
      endcase
    end
    next_control = control;
    next_irqMask = irqMask;
    // Writes to the line status word fall through and are ignored
    if (wrTaken && address == CONTROL_OFS) begin // [RULE_14]
      next_control = writedata[2:0];
    end
    if (wrTaken && address == IRQ_MASK_OFS) begin
      next_irqMask = writedata[2:0];
    end
    next_irqStatus = irqStatus;
    if (wrTaken && address == IRQ_STATUS_OFS) begin
      next_irqStatus = irqStatus & ~writedata[2:0];
    end
    // Rising holding empty, break and error summary flags set sticky bits; a set beats a same-cycle clear
    if (flags.txHoldingEmpty && !prevFlags.txHoldingEmpty) begin
      next_irqStatus[IRQ_HOLD_BIT] = 1'b1;
    end
    if (flags.breakFlag && !prevFlags.breakFlag) begin
      next_irqStatus[IRQ_BREAK_BIT] = 1'b1;
    end
    if (flags.errorSummary && !prevFlags.errorSummary) begin
      next_irqStatus[IRQ_ERR_BIT] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      control   <= CTRL_RESET;
      irqStatus <= IRQ_RESET;
      irqMask   <= IRQ_RESET;
      ack       <= 1'b0;
      readdata  <= 32'h0;
      rdPtr     <= '0;
      wrPtr     <= '0;
      rxCount   <= '0;
      errCount  <= '0;
      txCount   <= '0;
      fifoModeQ <= 1'b0;
      // Idle levels, so leaving reset sets no sticky bit
      prevFlags <= '{errorSummary: 1'b0, transmitterEmpty: 1'b1,
                     txHoldingEmpty: 1'b1, breakFlag: 1'b0};
    end else begin
      control   <= next_control;
      irqStatus <= next_irqStatus;
      irqMask   <= next_irqMask;
      ack       <= next_ack;
      readdata  <= next_readdata;
      rdPtr     <= next_rdPtr;
      wrPtr     <= next_wrPtr;
      rxCount   <= next_rxCount;
      errCount  <= next_errCount;
      txCount   <= next_txCount;
      fifoModeQ <= fifoMode;
      prevFlags <= flags;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  err_read_clear_a: assert property ( // [RULE_01]
    !fifoMode && !flush && rxRead && rxCount != '0 && !pushValid |=> !flags.errorSummary)
    else $error("error summary not cleared by buffer read");

  err_fifo_hold_a: assert property ( // [RULE_02]
    fifoMode && !flush && pushValid && pushErr && !pop && rxCount < FIFO_DEPTH
    |=> flags.errorSummary [*1] ##1 (flags.errorSummary || $past(pop)))
    else $error("error summary lost while erroneous entry held");

  tx_empty_both_a: assert property ( // [RULE_03] [RULE_04]
    flags.transmitterEmpty |-> txCount == '0 && !txShiftBusy && flags.txHoldingEmpty)
    else $error("transmitter empty while a character is held");

  hold_irq_a: assert property ( // [RULE_05]
    flags.txHoldingEmpty && control[CTRL_TXIRQ_BIT] |-> txEmptyIrq)
    else $error("holding empty interrupt missing");

  hold_clear_a: assert property ( // [RULE_06] [RULE_07]
    !flush && txWrite && !txFull && !txShiftLoad |=> !flags.txHoldingEmpty)
    else $error("holding empty not cleared by a write");

  hold_set_a: assert property ( // [RULE_06] [RULE_07]
    !flush && txShiftLoad && txCount == 5'h01 && !txWrite |=> flags.txHoldingEmpty)
    else $error("holding empty not set after last transfer");

  break_irq_a: assert property ( // [RULE_10]
    flags.breakFlag && control[CTRL_LSIRQ_BIT] |-> lineStatusIrq)
    else $error("break interrupt missing");

  break_head_a: assert property ( // [RULE_12] [RULE_13]
    fifoMode && !flush && pop && rxCount >= 5'h02 |=> flags.breakFlag == $past(tagMem[rdPtr + 4'h1].brk))
    else $error("break flag does not track the next entry");

  reserved_zero_a: assert property ( // [RULE_16]
    read && ack && address == LINE_STATUS_OFS |-> readdata[31:8] == 24'h0)
    else $error("reserved status bits not zero");

  status_ro_a: assert property ( // [RULE_14]
    write && ack && address == LINE_STATUS_OFS |=> control == $past(control) && irqMask == $past(irqMask))
    else $error("write to line status changed a register");

endmodule // uart_line_status_flags

/* verilog/uart_lsf_pkg.sv */
// Constants and types shared by the line status flag block
package uart_lsf_pkg;

  // Register byte offsets on the Avalon slave
  localparam logic [3:0] LINE_STATUS_OFS = 4'h0;
  localparam logic [3:0] CONTROL_OFS     = 4'h4;
  localparam logic [3:0] IRQ_STATUS_OFS  = 4'h8;
  localparam logic [3:0] IRQ_MASK_OFS    = 4'hc;

  // Line status word bit positions
  localparam int ERR_SUMMARY_BIT = 7;
  localparam int TX_EMPTY_BIT    = 6;
  localparam int HOLD_EMPTY_BIT  = 5;
  localparam int BREAK_BIT       = 4;

  // Control register bit positions
  localparam int CTRL_FIFO_BIT  = 0;
  localparam int CTRL_TXIRQ_BIT = 1;
  localparam int CTRL_LSIRQ_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // Interrupt status and mask bit positions
  localparam int IRQ_HOLD_BIT  = 0;
  localparam int IRQ_BREAK_BIT = 1;
  localparam int IRQ_ERR_BIT   = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // FIFO geometry
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FIFO_DEPTH = 5'h10;
  localparam logic [CNT_W-1:0] BUF_DEPTH  = 5'h01;

  // Break detection counter width
  localparam int BRK_CNT_W = 5;

  typedef struct packed {
    logic parity;
    logic framing;
    logic brk;
  } rx_tag_t;

  typedef struct packed {
    logic errorSummary;
    logic transmitterEmpty;
    logic txHoldingEmpty;
    logic breakFlag;
  } line_flags_t;

endpackage

/* verilog/break_detect.sv */
// Break detector on the serial receive line
`timescale 1ns/1ps
module break_detect
  import uart_lsf_pkg::*;
(
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst_b,
  // Line and bit timing
  input  wire logic                 rxLine,
  input  wire logic                 baudTick,
  input  wire logic [3:0]           charBits,
  // Result
  output logic                      breakPulse
);

  logic [BRK_CNT_W-1:0] lowBits;
  logic [BRK_CNT_W-1:0] next_lowBits;
  logic                 armed;
  logic                 next_armed;
  logic                 next_breakPulse;

  always_comb begin
    next_lowBits    = lowBits;
    next_armed      = armed;
    next_breakPulse = 1'b0;
    if (rxLine) begin
      next_lowBits = '0;
      next_armed   = 1'b1;
    end else if (baudTick && armed) begin
      // A full character of low bits seen; one more means longer than that
      if (lowBits == {1'b0, charBits}) begin // [RULE_09]
        next_breakPulse = 1'b1;
        next_armed      = 1'b0;
      end else begin
        next_lowBits = lowBits + 5'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lowBits    <= '0;
      armed      <= 1'b0;
      breakPulse <= 1'b0;
    end else begin
      lowBits    <= next_lowBits;
      armed      <= next_armed;
      breakPulse <= next_breakPulse;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  break_after_char_a: assert property ( // [RULE_09]
    !rxLine && baudTick && armed && lowBits == {1'b0, charBits} |=> breakPulse)
    else $error("break not flagged after a full low character");

  break_needs_low_a: assert property ( // [RULE_09]
    breakPulse |-> $past(!rxLine) && $past(baudTick))
    else $error("break flagged without low line on a bit tick");

endmodule // break_detect

/* testbench/remote_line_model.sv */
// Far-end line model: free-running bit tick and a receive line held low on demand
`timescale 1ns/1ps
module remote_line_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // Bench control
  input  wire logic       start,
  input  wire logic [4:0] lowTicks,
  // Serial side
  output logic            rxLine,
  output logic            baudTick
);
  logic [1:0] div;
  logic [4:0] cnt;

  // Line idles high; released as soon as the requested low ticks have gone by
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div <= 2'h0;
      cnt <= 5'h0;
      rxLine <= 1'b1;
      baudTick <= 1'b0;
    end else begin
      div <= div + 2'h1;
      baudTick <= (div == 2'h3);
      if (start) begin
        rxLine <= 1'b0;
        cnt <= 5'h0;
      end else if (!rxLine && baudTick) begin
        cnt <= cnt + 5'h1;
        if (cnt + 5'h1 == lowTicks) begin
          rxLine <= 1'b1;
        end
      end
    end
  end
endmodule // remote_line_model

/* testbench/uart_line_status_flags_tb.sv */
// Self-checking bench for the line status flag block
`timescale 1ns/1ps
module uart_line_status_flags_tb import uart_lsf_pkg::*;;
  logic        sys_clk, rst_b, read, write, waitrequest, irq;
  logic        rxCharValid, rxRead, txWrite, txShiftLoad, txShiftBusy;
  logic        txFull, txEmptyIrq, lineStatusIrq, rxLine, baudTick, start;
  logic [3:0]  address, charBits;
  logic [4:0]  lowTicks;
  logic [31:0] writedata, readdata;
  rx_tag_t     rxCharTag;
  int          err_total, checks_done;

  uart_line_status_flags uart_line_status_flags_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .rxLine(rxLine), .baudTick(baudTick),
    .charBits(charBits), .rxCharValid(rxCharValid), .rxCharTag(rxCharTag),
    .rxRead(rxRead), .txWrite(txWrite), .txShiftLoad(txShiftLoad),
    .txShiftBusy(txShiftBusy), .txFull(txFull), .txEmptyIrq(txEmptyIrq),
    .lineStatusIrq(lineStatusIrq), .irq(irq));

  remote_line_model remote_line_model_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .start(start), .lowTicks(lowTicks),
    .rxLine(rxLine), .baudTick(baudTick));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask

  task automatic stall(input int k);
    if (k >= 200) begin
      err_total++;
      $display("unexpected at %0t: wait ran out", $time);
      print_verdict();
    end
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    for (n = 0; n < 200; n++) begin
      @(posedge sys_clk);
      if (waitrequest === 1'b0) break;
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    stall(n);
  endtask

  // Ends on a falling edge so flags that follow the write have settled
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    @(negedge sys_clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    cmp(q, exp);
  endtask

  task automatic push(input rx_tag_t t);
    @(posedge sys_clk);
    rxCharValid <= 1'b1;
    rxCharTag <= t;
    @(posedge sys_clk);
    rxCharValid <= 1'b0;
  endtask

  task automatic pop;
    @(posedge sys_clk);
    rxRead <= 1'b1;
    @(posedge sys_clk);
    rxRead <= 1'b0;
  endtask

  task automatic txw(input int n);
    @(posedge sys_clk);
    txWrite <= 1'b1;
    repeat (n) @(posedge sys_clk);
    txWrite <= 1'b0;
  endtask

  task automatic load(input int n);
    @(posedge sys_clk);
    txShiftLoad <= 1'b1;
    txShiftBusy <= 1'b1;
    repeat (n) @(posedge sys_clk);
    txShiftLoad <= 1'b0;
  endtask

  task automatic brk(input logic [4:0] n);
    int k;
    @(posedge sys_clk);
    lowTicks <= n;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    for (k = 0; k < 200; k++) begin
      @(posedge sys_clk);
      if (rxLine === 1'b1) break;
    end
    stall(k);
    repeat (4) @(posedge sys_clk);
  endtask

  // Reads the line status and interrupt status reset values and unmapped offset 4'h1, then writes ones to clear the interrupt status
  task automatic s_reset;
    rd(LINE_STATUS_OFS, 32'h60);
    rd(4'h1, 32'h0);
    rd(IRQ_STATUS_OFS, 32'h0);
    cmp(irq, 1'b0);
    wr(IRQ_STATUS_OFS, 32'h7);
  endtask

  task automatic s_tx_plain;
    wr(CONTROL_OFS, 32'h2);
    cmp(txEmptyIrq, 1'b1);
    txw(1);
    rd(LINE_STATUS_OFS, 32'h0);
    cmp(txFull, 1'b1);
    cmp(txEmptyIrq, 1'b0);
    load(1);
    rd(LINE_STATUS_OFS, 32'h20);
    @(posedge sys_clk);
    txShiftBusy <= 1'b0;
    rd(LINE_STATUS_OFS, 32'h60);
    rd(IRQ_STATUS_OFS, 32'h1);
    wr(IRQ_MASK_OFS, 32'h1);
    cmp(irq, 1'b1);
    wr(IRQ_STATUS_OFS, 32'h1);
    cmp(irq, 1'b0);
    wr(IRQ_MASK_OFS, 32'h0);
  endtask

  task automatic s_rx_plain;
    rx_tag_t t [3] = '{3'h4, 3'h2, 3'h1};
    foreach (t[i]) begin
      push(t[i]);
      rd(LINE_STATUS_OFS, t[i].brk ? 32'hf0 : 32'he0);
      pop();
      rd(LINE_STATUS_OFS, 32'h60);
    end
  endtask

  // Exactly one character time low must not count as a break
  task automatic s_break;
    wr(CONTROL_OFS, 32'h4);
    brk(5'ha);
    rd(LINE_STATUS_OFS, 32'h60);
    cmp(lineStatusIrq, 1'b0);
    brk(5'hb);
    rd(LINE_STATUS_OFS, 32'hf0);
    cmp(lineStatusIrq, 1'b1);
    pop();
    rd(LINE_STATUS_OFS, 32'h60);
    cmp(lineStatusIrq, 1'b0);
    // Shorter character: the threshold must follow charBits
    @(posedge sys_clk);
    charBits <= 4'h7;
    brk(5'h7);
    rd(LINE_STATUS_OFS, 32'h60);
    brk(5'h8);
    rd(LINE_STATUS_OFS, 32'hf0);
    pop();
    rd(LINE_STATUS_OFS, 32'h60);
  endtask

  task automatic s_fifo_rx;
    wr(CONTROL_OFS, 32'h1);
    push(3'h0);
    push(3'h1);
    push(3'h1);
    push(3'h0);
    rd(LINE_STATUS_OFS, 32'he0);
    pop();
    rd(LINE_STATUS_OFS, 32'hf0);
    pop();
    rd(LINE_STATUS_OFS, 32'hf0);
    pop();
    rd(LINE_STATUS_OFS, 32'h60);
    pop();
  endtask

  // Sixteen writes from empty stay within the FIFO
  task automatic s_fifo_tx;
    wr(CONTROL_OFS, 32'h3);
    txw(16);
    rd(LINE_STATUS_OFS, 32'h0);
    cmp(txFull, 1'b1);
    cmp(txEmptyIrq, 1'b0);
    load(15);
    rd(LINE_STATUS_OFS, 32'h0);
    cmp(txFull, 1'b0);
    load(1);
    rd(LINE_STATUS_OFS, 32'h20);
    cmp(txEmptyIrq, 1'b1);
    @(posedge sys_clk);
    txShiftBusy <= 1'b0;
    rd(LINE_STATUS_OFS, 32'h60);
  endtask

  initial begin
    err_total = 0;
    checks_done = 0;
    rst_b = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    charBits = 4'ha;
    writedata = 32'h0;
    rxCharValid = 1'b0;
    rxCharTag = 3'h0;
    rxRead = 1'b0;
    txWrite = 1'b0;
    txShiftLoad = 1'b0;
    txShiftBusy = 1'b0;
    start = 1'b0;
    lowTicks = 5'h0;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    s_reset();
    s_tx_plain();
    s_rx_plain();
    s_break();
    s_fifo_rx();
    s_fifo_tx();
    print_verdict();
  end
endmodule // uart_line_status_flags_tb
